/* File: rtl/soc_fabric_axi_bridges_consts.vh */
// Operation
// - light bridge window spans 2 MB
// - cores, dma, debug port all issue
// - light bridge fabric data fixed 32 bits
// - 32b address, 4b id, 16 outstanding
// - f2s master on subsystem clock, slave fabric clock
// - every bridge crosses clocks asynchronously
// - hp master on fabric bridge clock
// - fabric supplies light bridge master clock
// - f2s bridge single active-low reset
// - hp bridge single active-low reset
// - light bridge single active-low reset
// - bridges stay reset until software release
// - hp fabric width 32, 64 or 128
// - convert to fixed internal 64-bit path
// - split exclusive access loses exclusive flag
// - merge four 2-byte beats into 64
// - merge two 4-byte beats into 64
// - optional ready latency pipeline stage
// - ready latency zero to four cycles
// - each bridge is slave-master pair
// - f2s fabric slave is 128 bits wide
// - hp bridge fabric space 4 GB
`ifndef SOC_FABRIC_AXI_BRIDGES_CONSTS_VH
`define SOC_FABRIC_AXI_BRIDGES_CONSTS_VH
`define LW_WINDOW_BYTES  33'h0_0020_0000
`define LW_DATA_W        32
`define LW_ADDR_W        32
`define LW_ID_W          4
`define LW_MAX_OUT       5'h10
`define HP_INT_W         64
`define HP_WIDTH_DEF     64
`define F2S_W            128
`define READY_LAT_MAX    4
`define READY_LAT_DEF    0
`define MERGE_BYTES      4'h8
`endif

/* File: rtl/soc_fabric_axi_bridges.v */
`timescale 1ns/1ps
`include "soc_fabric_axi_bridges_consts.vh"
module soc_fabric_axi_bridges #(
  parameter [32:0] LW_BASE   = 33'h0_0000_0000,
  parameter        HP_WIDTH  = `HP_WIDTH_DEF,
  parameter        READY_LAT = `READY_LAT_DEF
) (
  input  wire                 clk,
  input  wire                 rst,
  input  wire                 fabric_to_soc_bridge_reset_n,
  input  wire                 soc_to_fabric_bridge_reset_n,
  input  wire                 light_bridge_reset_n,
  input  wire                 light_bridge_master_clock,
  input  wire                 soc_to_fabric_master_clock,
  input  wire                 fabric_to_soc_slave_clock,
  input  wire                 lw_req_valid,
  output reg                  lw_req_ready,
  input  wire                 lw_req_write,
  input  wire [1:0]           lw_req_source,
  input  wire [31:0]          lw_req_addr,
  input  wire [31:0]          lw_req_wdata,
  input  wire [3:0]           lw_req_id,
  output reg                  lw_rsp_valid,
  output reg  [3:0]           lw_rsp_id,
  output reg  [31:0]          lw_rsp_rdata,
  output reg                  lw_rsp_error,
  output reg                  lw_rsp_write,
  output reg                  lw_fab_valid,
  input  wire                 lw_fab_ready,
  output reg                  lw_fab_write,
  output reg  [31:0]          lw_fab_addr,
  output reg  [31:0]          lw_fab_wdata,
  output reg  [3:0]           lw_fab_id,
  input  wire                 lw_fab_rsp_valid,
  input  wire                 lw_fab_rsp_write,
  input  wire                 lw_fab_rsp_error,
  input  wire [3:0]           lw_fab_rsp_id,
  input  wire [31:0]          lw_fab_rsp_rdata,
  input  wire                 hp_in_valid,
  output reg                  hp_in_ready,
  input  wire [63:0]          hp_in_data,
  input  wire                 hp_in_excl,
  output reg                  hp_out_valid,
  input  wire                 hp_out_ready,
  output reg  [HP_WIDTH-1:0]  hp_out_data,
  output reg                  hp_out_excl,
  input  wire                 hp_nb_valid,
  input  wire [31:0]          hp_nb_data,
  input  wire [3:0]           hp_nb_bytes,
  input  wire                 hp_nb_last,
  output reg                  hp_mrg_valid,
  output reg  [63:0]          hp_mrg_data,
  input  wire                 f2s_fab_valid,
  output reg                  f2s_fab_ready,
  input  wire [127:0]         f2s_fab_data,
  output reg                  f2s_soc_valid,
  input  wire                 f2s_soc_ready,
  output reg  [127:0]         f2s_soc_data
);
  // sample point: falling edge of a link clock, mid-period of fabric signals
  function fall_seen;
    input cur;
    input prev;
    begin
      fall_seen = prev & ~cur;
    end
  endfunction

  // two-stage synchronisers for resets, link clocks and fabric inputs
  reg  [2:0]   rs1_reg, rs2_reg;
  reg  [2:0]   ck1_reg, ck2_reg, ck3_reg;
  reg  [38:0]  lwi1_reg, lwi2_reg;
  reg          lwr1_reg, lwr2_reg;
  reg  [37:0]  hpi1_reg, hpi2_reg;
  reg          hpr1_reg, hpr2_reg;
  reg  [128:0] f2i1_reg, f2i2_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rs1_reg  <= 3'h0;
      rs2_reg  <= 3'h0;
      ck1_reg  <= 3'h0;
      ck2_reg  <= 3'h0;
      ck3_reg  <= 3'h0;
      lwi1_reg <= 39'h0;
      lwi2_reg <= 39'h0;
      lwr1_reg <= 1'b0;
      lwr2_reg <= 1'b0;
      hpi1_reg <= 38'h0;
      hpi2_reg <= 38'h0;
      hpr1_reg <= 1'b0;
      hpr2_reg <= 1'b0;
      f2i1_reg <= 129'h0;
      f2i2_reg <= 129'h0;
    end else begin
      rs1_reg  <= {fabric_to_soc_bridge_reset_n, soc_to_fabric_bridge_reset_n,
                   light_bridge_reset_n};
      rs2_reg  <= rs1_reg;
      ck1_reg  <= {fabric_to_soc_slave_clock, soc_to_fabric_master_clock,
                   light_bridge_master_clock};
      ck2_reg  <= ck1_reg;
      ck3_reg  <= ck2_reg;
      lwi1_reg <= {lw_fab_rsp_valid, lw_fab_rsp_write, lw_fab_rsp_error,
                   lw_fab_rsp_id, lw_fab_rsp_rdata};
      lwi2_reg <= lwi1_reg;
      lwr1_reg <= lw_fab_ready;
      lwr2_reg <= lwr1_reg;
      hpi1_reg <= {hp_nb_valid, hp_nb_last, hp_nb_bytes, hp_nb_data};
      hpi2_reg <= hpi1_reg;
      hpr1_reg <= hp_out_ready;
      hpr2_reg <= hpr1_reg;
      f2i1_reg <= {f2s_fab_valid, f2s_fab_data};
      f2i2_reg <= f2i1_reg;
    end
  end

  // bridge held while global reset is high or its own reset line is low
  wire lw_hold  = ~rs2_reg[0];
  wire hp_hold  = ~rs2_reg[1];
  wire f2s_hold = ~rs2_reg[2];
  wire lw_edge  = fall_seen(ck2_reg[0], ck3_reg[0]);
  wire hp_edge  = fall_seen(ck2_reg[1], ck3_reg[1]);
  wire f2s_edge = fall_seen(ck2_reg[2], ck3_reg[2]);

  // light bridge: window decode and outstanding limits
  wire [32:0] lw_off   = {1'b0, lw_req_addr} - LW_BASE;
  wire        lw_inwin = ({1'b0, lw_req_addr} >= LW_BASE) &&
                         (lw_off < `LW_WINDOW_BYTES);
  wire        lw_take  = lw_req_valid & lw_req_ready;
  wire        lw_push  = lw_take & lw_inwin;
  wire        lw_rtake = lw_edge & lwi2_reg[38];
  reg  [4:0]  lw_rd_reg, lw_wr_reg;
  reg  [4:0]  lw_rd_next, lw_wr_next;
  reg         lw_err_reg, lw_err_next;
  reg  [4:0]  lw_err_id_reg;
  reg         lw_err_wr_reg;

  // two-entry buffer between the soc-side slave and the fabric-side master
  reg  [68:0] lw_b0_reg, lw_b1_reg;
  reg  [1:0]  lw_bc_reg, lw_bc_next;
  wire        lw_pop   = lw_edge & (lw_bc_reg != 2'h0) & (~lw_fab_valid | lwr2_reg);
  wire        lw_done  = lw_edge & lw_fab_valid & lwr2_reg;
  wire [68:0] lw_entry = {lw_req_write, lw_req_id, lw_req_addr, lw_req_wdata};

  always @* begin
    lw_bc_next = lw_bc_reg + {1'b0, lw_push} - {1'b0, lw_pop};
    lw_rd_next = lw_rd_reg;
    lw_wr_next = lw_wr_reg;
    if (lw_push & ~lw_req_write)
      lw_rd_next = lw_rd_next + 5'h01;
    if (lw_push & lw_req_write)
      lw_wr_next = lw_wr_next + 5'h01;
    if (lw_rtake & ~lwi2_reg[37])
      lw_rd_next = lw_rd_next - 5'h01;
    if (lw_rtake & lwi2_reg[37])
      lw_wr_next = lw_wr_next - 5'h01;
    lw_err_next = (lw_err_reg & lw_rtake) | (lw_take & ~lw_inwin);
  end

  // soc-side slave of the light bridge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lw_req_ready  <= 1'b0;
      lw_rd_reg     <= 5'h00;
      lw_wr_reg     <= 5'h00;
      lw_bc_reg     <= 2'h0;
      lw_b0_reg     <= 69'h0;
      lw_b1_reg     <= 69'h0;
      lw_err_reg    <= 1'b0;
      lw_err_id_reg <= 5'h00;
      lw_err_wr_reg <= 1'b0;
      lw_rsp_valid  <= 1'b0;
      lw_rsp_id     <= 4'h0;
      lw_rsp_rdata  <= 32'h0000_0000;
      lw_rsp_error  <= 1'b0;
      lw_rsp_write  <= 1'b0;
    end else if (lw_hold) begin
      lw_req_ready  <= 1'b0;
      lw_rd_reg     <= 5'h00;
      lw_wr_reg     <= 5'h00;
      lw_bc_reg     <= 2'h0;
      lw_err_reg    <= 1'b0;
      lw_rsp_valid  <= 1'b0;
    end else begin
      lw_rd_reg  <= lw_rd_next;
      lw_wr_reg  <= lw_wr_next;
      lw_bc_reg  <= lw_bc_next;
      lw_err_reg <= lw_err_next;
      // no more than sixteen in flight, reads and writes together
      lw_req_ready <= (lw_bc_next != 2'h2) & ~lw_err_next &
                      ((lw_rd_next + lw_wr_next) < `LW_MAX_OUT);
      if (lw_pop)
        lw_b0_reg <= (lw_bc_reg == 2'h2) ? lw_b1_reg : lw_entry;
      if (lw_push & ((lw_bc_reg == 2'h0 & ~lw_pop) | (lw_bc_reg == 2'h1 & lw_pop)))
        lw_b0_reg <= lw_entry;
      if (lw_push & ((lw_bc_reg == 2'h1 & ~lw_pop) | (lw_bc_reg == 2'h2)))
        lw_b1_reg <= lw_entry;
      if (lw_take & ~lw_inwin) begin
        lw_err_id_reg <= {1'b0, lw_req_id};
        lw_err_wr_reg <= lw_req_write;
      end
      // fabric answers win; an out-of-window error waits one cycle
      lw_rsp_valid <= lw_rtake | lw_err_reg;
      if (lw_rtake) begin
        lw_rsp_write <= lwi2_reg[37];
        lw_rsp_error <= lwi2_reg[36];
        lw_rsp_id    <= lwi2_reg[35:32];
        lw_rsp_rdata <= lwi2_reg[31:0];
      end else if (lw_err_reg) begin
        lw_rsp_write <= lw_err_wr_reg;
        lw_rsp_error <= 1'b1;
        lw_rsp_id    <= lw_err_id_reg[3:0];
        lw_rsp_rdata <= 32'h0000_0000;
      end
    end
  end

  // fabric-side master of the light bridge, 32-bit data fixed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lw_fab_valid <= 1'b0;
      lw_fab_write <= 1'b0;
      lw_fab_addr  <= 32'h0000_0000;
      lw_fab_wdata <= 32'h0000_0000;
      lw_fab_id    <= 4'h0;
    end else if (lw_hold) begin
      lw_fab_valid <= 1'b0;
    end else if (lw_pop) begin
      lw_fab_valid <= 1'b1;
      lw_fab_write <= lw_b0_reg[68];
      lw_fab_id    <= lw_b0_reg[67:64];
      lw_fab_addr  <= lw_b0_reg[63:32];
      lw_fab_wdata <= lw_b0_reg[31:0];
    end else if (lw_done) begin
      lw_fab_valid <= 1'b0;
    end
  end

  // hp ready latency: fabric ready seen through 0..4 link-clock stages
  reg  [3:0] hp_rp_reg;
  wire [4:0] hp_rp_all = {hp_rp_reg, hpr2_reg};
  wire       hp_rdy    = hp_rp_all[READY_LAT];
  wire       hp_adv    = hp_edge & (~hp_out_valid | hp_rdy);
  wire       hp_take   = hp_in_valid & hp_in_ready;
  reg  [127:0] hp_acc_reg;
  reg          hp_exc_reg;
  reg  [1:0]   hp_cnt_reg;
  wire         hp_full = (HP_WIDTH == 128) ? (hp_cnt_reg == 2'h2)
                                           : (hp_cnt_reg != 2'h0);

  // hp width converter between internal 64 bits and the fabric width
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hp_rp_reg    <= 4'h0;
      hp_in_ready  <= 1'b0;
      hp_acc_reg   <= 128'h0;
      hp_exc_reg   <= 1'b0;
      hp_cnt_reg   <= 2'h0;
      hp_out_valid <= 1'b0;
      hp_out_data  <= {HP_WIDTH{1'b0}};
      hp_out_excl  <= 1'b0;
    end else if (hp_hold) begin
      hp_rp_reg    <= 4'h0;
      hp_in_ready  <= 1'b0;
      hp_cnt_reg   <= 2'h0;
      hp_out_valid <= 1'b0;
    end else begin
      if (hp_edge)
        hp_rp_reg <= {hp_rp_reg[2:0], hpr2_reg};
      hp_in_ready <= ~hp_full & ~hp_take;
      if (hp_take) begin
        if (HP_WIDTH == 128 && hp_cnt_reg == 2'h1) begin
          hp_acc_reg[127:64] <= hp_in_data;
          hp_exc_reg         <= hp_exc_reg & hp_in_excl;
          hp_cnt_reg         <= 2'h2;
        end else begin
          hp_acc_reg <= {64'h0, hp_in_data};
          hp_exc_reg <= hp_in_excl;
          hp_cnt_reg <= (HP_WIDTH == 32) ? 2'h2 : 2'h1;
        end
      end
      // a take never coincides with a full buffer; fabric acceptance still lands
      if (hp_adv & hp_full) begin
        hp_out_valid <= 1'b1;
        hp_out_data  <= hp_acc_reg[HP_WIDTH-1:0];
        if (HP_WIDTH == 32) begin
          hp_out_excl <= 1'b0;
          hp_acc_reg  <= {32'h0, hp_acc_reg[127:32]};
          hp_cnt_reg  <= hp_cnt_reg - 2'h1;
        end else begin
          hp_out_excl <= hp_exc_reg;
          hp_cnt_reg  <= 2'h0;
        end
      end else if (hp_adv) begin
        hp_out_valid <= 1'b0;
      end
    end
  end

  // hp narrow-beat merge: 2-byte or 4-byte beats packed into one 64-bit beat
  reg  [63:0] hp_mg_reg;
  reg  [3:0]  hp_mb_reg;
  wire        hp_nb_take = hp_edge & hpi2_reg[37];
  wire [3:0]  hp_mb_sum  = hp_mb_reg + hpi2_reg[35:32];
  wire [63:0] hp_nb_mask = (hpi2_reg[35:32] == 4'h2) ? 64'h0000_0000_0000_ffff
                                                    : 64'h0000_0000_ffff_ffff;
  wire [63:0] hp_nb_word = ({32'h0, hpi2_reg[31:0]} & hp_nb_mask) << {hp_mb_reg, 3'h0};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hp_mg_reg    <= 64'h0;
      hp_mb_reg    <= 4'h0;
      hp_mrg_valid <= 1'b0;
      hp_mrg_data  <= 64'h0;
    end else if (hp_hold) begin
      hp_mb_reg    <= 4'h0;
      hp_mrg_valid <= 1'b0;
    end else begin
      hp_mrg_valid <= 1'b0;
      if (hp_nb_take) begin
        if (hp_mb_sum >= `MERGE_BYTES || hpi2_reg[36]) begin
          hp_mrg_valid <= 1'b1;
          hp_mrg_data  <= hp_mg_reg | hp_nb_word;
          hp_mg_reg    <= 64'h0;
          hp_mb_reg    <= 4'h0;
        end else begin
          hp_mg_reg <= hp_mg_reg | hp_nb_word;
          hp_mb_reg <= hp_mb_sum;
        end
      end
    end
  end

  // fabric-to-soc bridge: 128-bit fabric slave, master on the subsystem clock
  wire f2s_take = f2s_edge & f2i2_reg[128] & f2s_fab_ready;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      f2s_fab_ready <= 1'b0;
      f2s_soc_valid <= 1'b0;
      f2s_soc_data  <= 128'h0;
    end else if (f2s_hold) begin
      f2s_fab_ready <= 1'b0;
      f2s_soc_valid <= 1'b0;
    end else begin
      if (f2s_take) begin
        f2s_soc_valid <= 1'b1;
        f2s_soc_data  <= f2i2_reg[127:0];
      end else if (f2s_soc_valid & f2s_soc_ready) begin
        f2s_soc_valid <= 1'b0;
      end
      if (f2s_edge)
        f2s_fab_ready <= ~f2s_soc_valid & ~f2s_take;
    end
  end

endmodule

/* File: sim/bridge_checker_assertions.sv */
`timescale 1ns/1ps
module bridge_checker (
  input wire         clk,
  input wire         rst,
  input wire         light_bridge_reset_n,
  input wire         soc_to_fabric_bridge_reset_n,
  input wire         fabric_to_soc_bridge_reset_n,
  input wire         lw_req_valid,
  input wire         lw_req_ready,
  input wire [31:0]  lw_req_addr,
  input wire         lw_rsp_valid,
  input wire         lw_rsp_error,
  input wire         lw_fab_valid,
  input wire         hp_in_valid,
  input wire         hp_in_ready,
  input wire         hp_out_valid,
  input wire         hp_mrg_valid,
  input wire         f2s_fab_ready,
  input wire         f2s_soc_valid,
  input wire         f2s_soc_ready,
  input wire [127:0] f2s_soc_data
);
  reg  [4:0] out_cnt_reg;
  wire       take = lw_req_valid && lw_req_ready;
  // light-bridge requests still waiting for their answer
  always @(posedge clk or posedge rst) begin
    if (rst)
      out_cnt_reg <= 5'h0;
    else if (!light_bridge_reset_n)
      out_cnt_reg <= 5'h0;
    else
      out_cnt_reg <= out_cnt_reg + {4'h0, take} - {4'h0, lw_rsp_valid};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rst_quiet: assert property ($fell(rst) |-> !lw_req_ready && !hp_in_ready)
    else $error("ready high right after reset");
  a_lw_held: assert property (!light_bridge_reset_n [*5] |-> !lw_req_ready && !lw_fab_valid)
    else $error("light bridge active in reset");
  a_hp_held: assert property (!soc_to_fabric_bridge_reset_n [*5] |-> !hp_in_ready && !hp_out_valid)
    else $error("hp bridge active in reset");
  a_f2s_held: assert property (!fabric_to_soc_bridge_reset_n [*5] |-> !f2s_fab_ready && !f2s_soc_valid)
    else $error("f2s bridge active in reset");
  a_window_error: assert property (take && lw_req_addr >= 32'h0020_0000 |-> ##[2:3] (lw_rsp_valid && lw_rsp_error))
    else $error("no error answer outside window");
  a_lw_max_out: assert property (take |-> out_cnt_reg < 5'h10)
    else $error("more than sixteen outstanding");
  a_rsp_pulse: assert property (lw_rsp_valid |=> !lw_rsp_valid)
    else $error("response longer than one cycle");
  a_hp_take_gap: assert property (hp_in_valid && hp_in_ready |=> !hp_in_ready)
    else $error("hp ready high after a take");
  a_mrg_pulse: assert property (hp_mrg_valid |=> !hp_mrg_valid)
    else $error("merge pulse too long");
  a_f2s_hold: assert property (f2s_soc_valid && !f2s_soc_ready && fabric_to_soc_bridge_reset_n
    |=> f2s_soc_valid && $stable(f2s_soc_data))
    else $error("f2s beat not held");
endmodule

bind soc_fabric_axi_bridges bridge_checker bridge_checker_i (.*);

/* File: sim/lw_fabric_model.sv */
`timescale 1ns/1ps
module lw_fabric_model (
  input  wire        lclk,
  input  wire        stall,
  input  wire        lw_fab_valid,
  input  wire        lw_fab_write,
  input  wire [31:0] lw_fab_addr,
  input  wire [31:0] lw_fab_wdata,
  input  wire [3:0]  lw_fab_id,
  output reg         lw_fab_ready,
  output reg         lw_fab_rsp_valid,
  output reg         lw_fab_rsp_write,
  output reg         lw_fab_rsp_error,
  output reg  [3:0]  lw_fab_rsp_id,
  output reg  [31:0] lw_fab_rsp_rdata
);
  reg [31:0] mem [0:15];
  reg        pend_reg = 1'b0;
  reg        wr_reg = 1'b0;
  reg [3:0]  id_reg = 4'h0;
  reg [3:0]  idx_reg = 4'h0;
  // idle levels at time zero
  initial begin
    lw_fab_ready = 1'b0;
    lw_fab_rsp_valid = 1'b0;
    lw_fab_rsp_write = 1'b0;
    lw_fab_rsp_error = 1'b0;
    lw_fab_rsp_id = 4'h0;
    lw_fab_rsp_rdata = 32'h0000_0000;
  end
  // one take per rising edge, answer held for exactly one period
  always @(posedge lclk) begin
    // ready reports what this rise accepted; the bridge reads it at the next fall
    lw_fab_ready <= !stall && lw_fab_valid;
    lw_fab_rsp_valid <= pend_reg;
    pend_reg <= !stall && lw_fab_valid;
    if (pend_reg) begin
      lw_fab_rsp_id <= id_reg;
      lw_fab_rsp_write <= wr_reg;
      lw_fab_rsp_rdata <= mem[idx_reg];
    end else begin
      lw_fab_rsp_id <= ~lw_fab_rsp_id; // released lines keep moving
      lw_fab_rsp_rdata <= ~lw_fab_rsp_rdata;
    end
    if (lw_fab_valid && !stall) begin
      id_reg <= lw_fab_id;
      wr_reg <= lw_fab_write;
      idx_reg <= lw_fab_addr[5:2];
      if (lw_fab_write)
        mem[lw_fab_addr[5:2]] <= lw_fab_wdata;
    end
  end
endmodule

/* File: sim/test_soc_fabric_axi_bridges.sv */
`timescale 1ns/1ps
module test_soc_fabric_axi_bridges;
  reg clk, rst, lclk, stall, lw_req_valid, lw_req_write, hp_in_valid, hp_in_excl, hp_out_ready;
  reg fabric_to_soc_bridge_reset_n, soc_to_fabric_bridge_reset_n, light_bridge_reset_n;
  reg hp_nb_valid, hp_nb_last, f2s_fab_valid, f2s_soc_ready;
  reg [1:0] lw_req_source;
  reg [3:0] lw_req_id, hp_nb_bytes;
  reg [31:0] lw_req_addr, lw_req_wdata, hp_nb_data;
  reg [63:0] hp_in_data;
  reg [127:0] f2s_fab_data;
  wire lw_req_ready, lw_rsp_valid, lw_rsp_error, lw_rsp_write, lw_fab_valid, lw_fab_ready;
  wire lw_fab_write, lw_fab_rsp_valid, lw_fab_rsp_write, lw_fab_rsp_error;
  wire hp_in_ready, hp_out_valid, hp_out_excl, hp_mrg_valid, f2s_fab_ready, f2s_soc_valid;
  wire [3:0] lw_rsp_id, lw_fab_id, lw_fab_rsp_id;
  wire [31:0] lw_rsp_rdata, lw_fab_addr, lw_fab_wdata, lw_fab_rsp_rdata;
  wire [63:0] hp_out_data, hp_mrg_data;
  wire [127:0] f2s_soc_data;
  wire light_bridge_master_clock = lclk;
  wire soc_to_fabric_master_clock = lclk;
  wire fabric_to_soc_slave_clock = lclk;
  integer mismatches, checks_done, n, i;

  soc_fabric_axi_bridges #(.READY_LAT(2)) soc_fabric_axi_bridges_i (.*);
  lw_fabric_model lw_fabric_model_i (.*);

  // subsystem clock and free-running fabric clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #200 lclk = ~lclk;
  end

  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task hang;
    begin
      mismatches = mismatches + 1;
      test_done;
    end
  endtask
  task chk(input [127:0] got, input [127:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one light-bridge request and its answer
  task lw_xfer(input w, input [1:0] s, input [31:0] a, input [31:0] d, input [3:0] id,
               input err, input [31:0] rd);
    begin
      @(posedge clk);
      lw_req_valid <= 1'b1; lw_req_write <= w; lw_req_source <= s;
      lw_req_addr <= a; lw_req_wdata <= d; lw_req_id <= id;
      @(negedge clk);
      for (n = 0; n < 400 && lw_req_ready !== 1'b1; n = n + 1) @(negedge clk);
      if (n == 400) hang;
      @(posedge clk);
      lw_req_valid <= 1'b0; lw_req_addr <= ~a; lw_req_wdata <= ~d;
      for (n = 0; n < 400 && lw_rsp_valid !== 1'b1; n = n + 1) @(negedge clk);
      if (n == 400) hang;
      chk(lw_rsp_error, err);
      chk(lw_rsp_id, id);
      chk(lw_rsp_write, w);
      if (!w && !err) chk(lw_rsp_rdata, rd);
    end
  endtask
  // hp beat held by a stalled fabric, then drained
  task hp_beat(input [63:0] d);
    begin
      @(posedge clk);
      hp_in_valid <= 1'b1; hp_in_data <= d; hp_in_excl <= 1'b1;
      @(negedge clk);
      for (n = 0; n < 400 && hp_in_ready !== 1'b1; n = n + 1) @(negedge clk);
      if (n == 400) hang;
      @(posedge clk);
      hp_in_valid <= 1'b0; hp_in_data <= ~d;
      for (n = 0; n < 400 && hp_out_valid !== 1'b1; n = n + 1) @(negedge clk);
      if (n == 400) hang;
      repeat (3) @(posedge lclk);
      @(negedge clk);
      chk(hp_out_valid, 1'b1);
      chk(hp_out_data, d);
      chk(hp_out_excl, 1'b1);
      @(posedge lclk) hp_out_ready <= 1'b1;
      for (n = 0; n < 400 && hp_out_valid !== 1'b0; n = n + 1) @(negedge clk);
      if (n == 400) hang;
      @(posedge lclk) hp_out_ready <= 1'b0;
    end
  endtask
  // narrow fabric beats merged into one 64-bit word
  task merge(input [3:0] b, input integer k, input [127:0] beats, input [63:0] exp);
    fork
      for (i = 0; i < k; i = i + 1) begin
        @(posedge lclk);
        hp_nb_valid <= 1'b1; hp_nb_bytes <= b; hp_nb_data <= beats[32*i +: 32];
      end
      begin
        for (n = 0; n < 400 && hp_mrg_valid !== 1'b1; n = n + 1) @(negedge clk);
        if (n == 400) hang;
        chk(hp_mrg_data, exp);
        @(posedge lclk) hp_nb_valid <= 1'b0;
        hp_nb_data <= ~hp_nb_data;
      end
    join
  endtask
  // fabric master beat crossing into the subsystem, stalled there
  task f2s_beat(input [127:0] d);
    begin
      @(posedge lclk);
      f2s_fab_valid <= 1'b1; f2s_fab_data <= d;
      for (n = 0; n < 50 && f2s_fab_ready !== 1'b1; n = n + 1) @(posedge lclk);
      if (n == 50) hang;
      @(posedge lclk); // hold valid through the fall that takes it
      f2s_fab_valid <= 1'b0; f2s_fab_data <= ~d;
      for (n = 0; n < 400 && f2s_soc_valid !== 1'b1; n = n + 1) @(negedge clk);
      if (n == 400) hang;
      repeat (5) @(negedge clk);
      chk(f2s_soc_data, d);
      @(posedge clk) f2s_soc_ready <= 1'b1;
      @(posedge clk) f2s_soc_ready <= 1'b0;
      @(negedge clk) chk(f2s_soc_valid, 1'b0);
    end
  endtask
  // light bridge reset asserted mid-run, then released by software
  task lw_reset;
    begin
      @(posedge clk) light_bridge_reset_n <= 1'b0;
      repeat (6) @(negedge clk);
      chk(lw_req_ready, 1'b0);
      @(posedge clk) light_bridge_reset_n <= 1'b1;
      for (n = 0; n < 40 && lw_req_ready !== 1'b1; n = n + 1) @(negedge clk);
      chk(lw_req_ready, 1'b1);
    end
  endtask

  initial begin
    {mismatches, checks_done} = 64'h0;
    {rst, stall, lw_req_valid, lw_req_write, hp_in_valid, hp_in_excl, hp_out_ready} = 7'h40;
    {hp_nb_valid, hp_nb_last, f2s_fab_valid, f2s_soc_ready} = 4'h0;
    {fabric_to_soc_bridge_reset_n, soc_to_fabric_bridge_reset_n, light_bridge_reset_n} = 3'h0;
    {lw_req_source, lw_req_id, hp_nb_bytes, lw_req_addr, lw_req_wdata, hp_nb_data} = 106'h0;
    {hp_in_data, f2s_fab_data} = 192'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    {fabric_to_soc_bridge_reset_n, soc_to_fabric_bridge_reset_n} <= 2'h3;
    light_bridge_reset_n <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
      lw_xfer(1'b1, i, 4 * i, 32'hC0DE_0000 + i, i, 1'b0, 0);
    for (i = 0; i < 3; i = i + 1)
      lw_xfer(1'b0, 2 - i, 4 * i, 0, 4'h8 + i, 1'b0, 32'hC0DE_0000 + i);
    lw_xfer(1'b1, 2'h2, 32'h001F_FFFC, 32'h5A5A_A5A5, 4'hF, 1'b0, 0);
    stall <= 1'b1;
    fork
      lw_xfer(1'b0, 2'h1, 32'h001F_FFFC, 0, 4'h7, 1'b0, 32'h5A5A_A5A5);
      begin repeat (40) @(posedge clk); stall <= 1'b0; end
    join
    lw_xfer(1'b0, 2'h0, 32'h0020_0000, 0, 4'h1, 1'b1, 0);
    lw_xfer(1'b1, 2'h3, 32'hFFFF_FFFC, 32'h1, 4'h2, 1'b1, 0);
    hp_beat(64'h0123_4567_89AB_CDEF);
    merge(4'h2, 4, {32'h0000_4444, 32'h0000_3333, 32'h0000_2222, 32'h0000_1111},
          64'h4444_3333_2222_1111);
    merge(4'h4, 2, {64'h0, 32'hBBBB_0002, 32'hAAAA_0001}, 64'hBBBB_0002_AAAA_0001);
    f2s_beat(128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF);
    lw_reset;
    lw_xfer(1'b0, 2'h0, 32'h0, 0, 4'h5, 1'b0, 32'hC0DE_0000);
    test_done;
  end
endmodule
